//--- core/pmc_pkg.sv
// constants, register map and state type of the power mode controller
package pmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] PMC_ADDR  = 8'h87;  // power_mode_control
  localparam logic [7:0] TYPE_ADDR = 8'h88;  // external irq type bits
  localparam logic [7:0] AUX_ADDR  = 8'h8E;  // auxiliary_control
  localparam logic [7:0] SER_ADDR  = 8'h98;  // serial_control, top bit only
  localparam logic [7:0] IEN_ADDR  = 8'hA8;  // irq_enable_reg shadow

  ////////////////////////////////////////////////////////////////////////////
  // power_mode_control fields
  localparam int PMC_BAUD  = 7;
  localparam int PMC_FESEL = 6;
  localparam int PMC_WTS   = 5;
  localparam int PMC_COLD  = 4;
  localparam int PMC_PD    = 1;
  localparam int PMC_IDL   = 0;
  localparam logic [7:0] PMC_RESET = 8'h00;
  localparam logic [7:0] PMC_COLD_MASK = 8'h10;

  // other fields
  localparam int TYP_ZERO      = 0;
  localparam int TYP_ONE       = 2;
  localparam int IEN_ZERO      = 0;
  localparam int IEN_ONE       = 2;
  localparam int AUX_ALE_DIS   = 0;
  localparam int AUX_WDT_PAUSE = 1;
  localparam int SER_TOP       = 7;
  localparam logic [7:0] TYPE_MASK = 8'h05;
  localparam logic [7:0] IEN_MASK  = 8'h05;
  localparam logic [7:0] AUX_MASK  = 8'h03;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ       = 100;  // 10 ns period, cycles per microsecond
  localparam int RST_PULSE_CYC = 2;
  localparam int WCNT_W        = 21;
  // start-up delays in microseconds, indexed by the fuse pair
  localparam int SUT_RC_US [4] = '{16, 512, 1024, 4096};
  localparam int SUT_XT_US [4] = '{1024, 2048, 4096, 16384};

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_PD,
    ST_WAKE_TIMED,
    ST_WAKE_EXT,
    ST_RST_WAKE,
    ST_RST_HOLD,
    ST_RST_PULSE
  } pmc_state_t;

endpackage : pmc_pkg

//--- core/pmc_power_mode_controller.sv
// power mode controller: idle, power-down, wake-up and power control flags
//
// Functional notes
// RQ1: writing idle request stops the cpu clock; cpu state is simply kept
// RQ2: port pins hold their levels while idle
// RQ3: timers and serial port keep clocked during idle
// RQ4: watchdog runs or pauses in idle per watchdog_pause_in_idle
// RQ5: brown-out detector stays on throughout idle
// RQ6: any enabled interrupt or reset ends idle; idle request cleared by hardware
// RQ7: interrupt ending idle is serviced at once, then code resumes after idle
// RQ8: power-down stops oscillator, brown-out detector and flash
// RQ9: hardware clears powerdown_request on wake from power-down
// RQ10: power-down ends only on external reset, power-on reset or qualified interrupt
// RQ11: only external irq 0 or 1, enabled and level typed, wake power-down
// RQ12: timed wake: falling edge restarts oscillator, cpu gated until timer expires
// RQ13: fuses set the timed delay; pin may rise early without effect
// RQ14: external wake: cpu clock gated until the pin rises again
// RQ15: board holds the irq pin low until the clock source is stable
// RQ16: reset pin activation in power-down restarts oscillator, runs start-up timer
// RQ17: reset released early gives two-cycle internal reset, else hold until release
// RQ18: cold_start_flag set at power-up, writable, untouched by warm resets
// RQ19: baud_double doubles the serial baud rate in modes 1 to 3
// RQ20: frame_error_select steers serial_control top bit; frame error always sets flag
// RQ21: power_mode_control at 87h, byte access only, reset 000X0000
// RQ22: latch_strobe_disable suppresses the address latch strobe
// RQ23: fuse pair and clock source pick the start-up delay
// RQ24: idle and power-down written together enter power-down
`timescale 1ns/1ps

module pmc_power_mode_controller #(
  parameter int CYC_PER_US = pmc_pkg::CLK_MHZ
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // system events, clock domain
  input  wire logic       warm_rst,
  input  wire logic       irq_pending,
  input  wire logic       frame_error,
  // board pins
  input  wire logic       ext_irq_zero_n,
  input  wire logic       ext_irq_one_n,
  input  wire logic       reset_pin,
  input  wire logic       reset_polarity_pin,
  // start-up fuses, static
  input  wire logic [1:0] sut_fuse,
  input  wire logic       clk_src_crystal,
  // power controls
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            wdt_clk_en,
  output logic            osc_en,
  output logic            bod_en,
  output logic            flash_pd,
  output logic            port_hold,
  output logic            cpu_reset,
  // peripheral controls
  output logic            ale_en,
  output logic            baud_double,
  output logic            serial_mode_bit,
  output logic            frame_error_flag
);

  localparam logic [pmc_pkg::WCNT_W-1:0] PULSE_LAST =
    pmc_pkg::WCNT_W'(pmc_pkg::RST_PULSE_CYC - 1);
  localparam logic [pmc_pkg::WCNT_W-1:0] CNT_ZERO = '0;

  ////////////////////////////////////////////////////////////////////////////
  // start-up delay, loaded as count minus one
  function automatic logic [pmc_pkg::WCNT_W-1:0] wake_last(
    input logic [1:0] fuse,
    input logic       xtal
  );
    int us;
    us = xtal ? pmc_pkg::SUT_XT_US[fuse] : pmc_pkg::SUT_RC_US[fuse];  // [RQ23]
    return pmc_pkg::WCNT_W'(us * CYC_PER_US - 1);                      // [RQ13]
  endfunction : wake_last

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] irq0_sync_r;
  logic [1:0] irq1_sync_r;
  logic [1:0] rpin_sync_r;
  logic [1:0] rpol_sync_r;
  logic       irq0_prev_r;
  logic       irq1_prev_r;
  logic       ract_prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq0_sync_r <= 2'h3;
      irq1_sync_r <= 2'h3;
      rpin_sync_r <= 2'h0;
      rpol_sync_r <= 2'h0;
    end else if (clk_en) begin
      irq0_sync_r <= {irq0_sync_r[0], ext_irq_zero_n};
      irq1_sync_r <= {irq1_sync_r[0], ext_irq_one_n};
      rpin_sync_r <= {rpin_sync_r[0], reset_pin};
      rpol_sync_r <= {rpol_sync_r[0], reset_polarity_pin};
    end
  end

  wire irq0_s   = irq0_sync_r[1];
  wire irq1_s   = irq1_sync_r[1];
  // reset pin is active high when the polarity strap is high
  wire rst_act  = rpol_sync_r[1] ? rpin_sync_r[1] : ~rpin_sync_r[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq0_prev_r <= 1'b1;
      irq1_prev_r <= 1'b1;
      // strap and pin syncs start at 0, so rst_act reads active for two cycles
      ract_prev_r <= 1'b1;
    end else if (clk_en) begin
      irq0_prev_r <= irq0_s;
      irq1_prev_r <= irq1_s;
      ract_prev_r <= rst_act;
    end
  end

  wire irq0_fall = irq0_prev_r & ~irq0_s;
  wire irq1_fall = irq1_prev_r & ~irq1_s;
  wire irq0_rise = ~irq0_prev_r & irq0_s;
  wire irq1_rise = ~irq1_prev_r & irq1_s;
  wire rst_rise  = ~ract_prev_r & rst_act;

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0] pmc_r;
  logic [7:0] pmc_nxt;
  logic [7:0] type_r;
  logic [7:0] ien_r;
  logic [7:0] aux_r;
  logic       sm_r;
  logic       fe_r;
  logic       fe_nxt;
  logic [7:0] rdata_r;

  wire wr_pmc  = clk_en & reg_wr & (reg_addr == pmc_pkg::PMC_ADDR);  // [RQ21]
  wire wr_type = clk_en & reg_wr & (reg_addr == pmc_pkg::TYPE_ADDR);
  wire wr_aux  = clk_en & reg_wr & (reg_addr == pmc_pkg::AUX_ADDR);
  wire wr_ser  = clk_en & reg_wr & (reg_addr == pmc_pkg::SER_ADDR);
  wire wr_ien  = clk_en & reg_wr & (reg_addr == pmc_pkg::IEN_ADDR);
  wire fesel   = pmc_r[pmc_pkg::PMC_FESEL];

  // only an enabled, level-typed external irq counts
  wire wake0 = irq0_fall & ien_r[pmc_pkg::IEN_ZERO] & ~type_r[pmc_pkg::TYP_ZERO];  // [RQ11]
  wire wake1 = irq1_fall & ien_r[pmc_pkg::IEN_ONE] & ~type_r[pmc_pkg::TYP_ONE];    // [RQ11]

  ////////////////////////////////////////////////////////////////////////////
  // power state machine
  pmc_pkg::pmc_state_t             st_r;
  pmc_pkg::pmc_state_t             st_nxt;
  logic [pmc_pkg::WCNT_W-1:0]      cnt_r;
  logic [pmc_pkg::WCNT_W-1:0]      cnt_nxt;
  logic                            src_r;
  logic                            src_nxt;

  wire cnt_done = (cnt_r == CNT_ZERO);
  wire src_rise = src_r ? irq1_rise : irq0_rise;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    src_nxt = src_r;
    unique case (st_r)
      pmc_pkg::ST_RUN: begin
        if (wr_pmc && reg_wdata[pmc_pkg::PMC_PD]) begin
          st_nxt = pmc_pkg::ST_PD;                                  // [RQ8] [RQ24]
        end else if (wr_pmc && reg_wdata[pmc_pkg::PMC_IDL]) begin
          st_nxt = pmc_pkg::ST_IDLE;                                // [RQ1]
        end
      end
      pmc_pkg::ST_IDLE: begin
        // cpu resumes where it stopped and vectors to the pending irq
        if (irq_pending) begin
          st_nxt = pmc_pkg::ST_RUN;                                 // [RQ6] [RQ7]
        end
      end
      pmc_pkg::ST_PD: begin
        if (rst_rise) begin
          st_nxt  = pmc_pkg::ST_RST_WAKE;                           // [RQ16]
          cnt_nxt = wake_last(sut_fuse, clk_src_crystal);
        end else if (wake0 || wake1) begin                          // [RQ10]
          src_nxt = ~wake0;
          if (pmc_r[pmc_pkg::PMC_WTS]) begin
            st_nxt  = pmc_pkg::ST_WAKE_TIMED;                       // [RQ12]
            cnt_nxt = wake_last(sut_fuse, clk_src_crystal);
          end else begin
            st_nxt = pmc_pkg::ST_WAKE_EXT;                          // [RQ14]
          end
        end
      end
      pmc_pkg::ST_WAKE_TIMED: begin
        // pin level ignored here, the delay always runs out
        if (cnt_done) begin
          st_nxt = pmc_pkg::ST_RUN;                                 // [RQ13]
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      pmc_pkg::ST_WAKE_EXT: begin
        // no timer: clock stability rests on the board's low time
        if (src_rise) begin
          st_nxt = pmc_pkg::ST_RUN;                                 // [RQ14] [RQ15]
        end
      end
      pmc_pkg::ST_RST_WAKE: begin
        if (!cnt_done) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (rst_act) begin
          st_nxt = pmc_pkg::ST_RST_HOLD;                            // [RQ17]
        end else begin
          st_nxt  = pmc_pkg::ST_RST_PULSE;                          // [RQ17]
          cnt_nxt = PULSE_LAST;
        end
      end
      pmc_pkg::ST_RST_HOLD: begin
        if (!rst_act) begin
          st_nxt = pmc_pkg::ST_RUN;
        end
      end
      pmc_pkg::ST_RST_PULSE: begin
        if (cnt_done) begin
          st_nxt = pmc_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
    // warm resets only reach us while the oscillator runs normally
    if (warm_rst && (st_r == pmc_pkg::ST_RUN || st_r == pmc_pkg::ST_IDLE)) begin
      st_nxt = pmc_pkg::ST_RUN;                                     // [RQ6]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r  <= pmc_pkg::ST_RUN;
      cnt_r <= CNT_ZERO;
      src_r <= 1'b0;
    end else if (clk_en) begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next values
  wire leave_idle = (st_r == pmc_pkg::ST_IDLE) && (st_nxt != pmc_pkg::ST_IDLE);
  wire leave_pd   = (st_r == pmc_pkg::ST_PD) && (st_nxt != pmc_pkg::ST_PD);

  always_comb begin
    pmc_nxt = pmc_r;
    if (wr_pmc) begin
      pmc_nxt = reg_wdata;                                          // [RQ18]
    end
    if (leave_idle || leave_pd) begin
      pmc_nxt[pmc_pkg::PMC_IDL] = 1'b0;                             // [RQ6]
    end
    if (leave_pd) begin
      pmc_nxt[pmc_pkg::PMC_PD] = 1'b0;                              // [RQ9]
    end
    if (warm_rst) begin
      pmc_nxt = (pmc_pkg::PMC_RESET & ~pmc_pkg::PMC_COLD_MASK)
              | (pmc_r & pmc_pkg::PMC_COLD_MASK);                   // [RQ18]
    end
  end

  always_comb begin
    fe_nxt = fe_r;
    if (warm_rst) begin
      fe_nxt = 1'b0;
    end else if (wr_ser && fesel) begin
      fe_nxt = reg_wdata[pmc_pkg::SER_TOP];                         // [RQ20]
    end
    // a frame error beats a clear in the same cycle
    if (frame_error) begin
      fe_nxt = 1'b1;                                                // [RQ20]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pmc_r <= pmc_pkg::PMC_RESET | pmc_pkg::PMC_COLD_MASK;         // [RQ18] [RQ21]
      fe_r  <= 1'b0;
    end else if (clk_en) begin
      pmc_r <= pmc_nxt;
      fe_r  <= fe_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      type_r <= pmc_pkg::REG_RESET;
      ien_r  <= pmc_pkg::REG_RESET;
      aux_r  <= pmc_pkg::REG_RESET;
      sm_r   <= 1'b0;
    end else if (warm_rst && clk_en) begin
      type_r <= pmc_pkg::REG_RESET;
      ien_r  <= pmc_pkg::REG_RESET;
      aux_r  <= pmc_pkg::REG_RESET;
      sm_r   <= 1'b0;
    end else begin
      if (wr_type) type_r <= reg_wdata & pmc_pkg::TYPE_MASK;
      if (wr_ien)  ien_r  <= reg_wdata & pmc_pkg::IEN_MASK;
      if (wr_aux)  aux_r  <= reg_wdata & pmc_pkg::AUX_MASK;
      if (wr_ser && !fesel) sm_r <= reg_wdata[pmc_pkg::SER_TOP];    // [RQ20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, data valid only the cycle after the strobe
  wire [7:0] ser_rd = {(fesel ? fe_r : sm_r), 7'h00};              // [RQ20]
  wire [7:0] rd_val = (reg_addr == pmc_pkg::PMC_ADDR)  ? pmc_r  :
                      (reg_addr == pmc_pkg::TYPE_ADDR) ? type_r :
                      (reg_addr == pmc_pkg::AUX_ADDR)  ? aux_r  :
                      (reg_addr == pmc_pkg::SER_ADDR)  ? ser_rd :
                      (reg_addr == pmc_pkg::IEN_ADDR)  ? ien_r  : pmc_pkg::REG_RESET;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= pmc_pkg::REG_RESET;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_val : pmc_pkg::REG_RESET;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // power control outputs
  wire in_idle = (st_r == pmc_pkg::ST_IDLE);
  wire in_pd   = (st_r == pmc_pkg::ST_PD);
  wire in_rst  = (st_r == pmc_pkg::ST_RST_HOLD) || (st_r == pmc_pkg::ST_RST_PULSE);

  // cpu clock must run through reset so the reset takes effect
  assign cpu_clk_en    = (st_r == pmc_pkg::ST_RUN) || in_rst;       // [RQ1] [RQ12] [RQ16]
  assign periph_clk_en = (st_r == pmc_pkg::ST_RUN) || in_idle;      // [RQ3]
  assign wdt_clk_en    = (st_r == pmc_pkg::ST_RUN)
                       || (in_idle && !aux_r[pmc_pkg::AUX_WDT_PAUSE]);  // [RQ4]
  assign osc_en        = !in_pd;                                    // [RQ8]
  assign bod_en        = !in_pd;                                    // [RQ5] [RQ8]
  assign flash_pd      = in_pd;                                     // [RQ8]
  assign port_hold     = in_idle || in_pd;                          // [RQ2]
  assign cpu_reset     = in_rst;                                    // [RQ17]
  assign ale_en        = !aux_r[pmc_pkg::AUX_ALE_DIS];              // [RQ22]
  assign baud_double   = pmc_r[pmc_pkg::PMC_BAUD];                  // [RQ19]
  assign serial_mode_bit  = sm_r;
  assign frame_error_flag = fe_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_idle_stop;
    @(posedge clk) disable iff (rst)
    (st_r == pmc_pkg::ST_RUN && wr_pmc && reg_wdata[pmc_pkg::PMC_IDL]
     && !reg_wdata[pmc_pkg::PMC_PD] && !warm_rst)
    |=> (in_idle && !cpu_clk_en && pmc_r[pmc_pkg::PMC_IDL]);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle entry failed"); // [RQ1]

  property p_idle_ports;
    @(posedge clk) disable iff (rst)
    in_idle |-> (port_hold && periph_clk_en);
  endproperty
  a_idle_ports: assert property (p_idle_ports) else $error("idle pins or timers"); // [RQ2]

  property p_idle_wdt;
    @(posedge clk) disable iff (rst)
    in_idle |-> (wdt_clk_en == !aux_r[pmc_pkg::AUX_WDT_PAUSE]);
  endproperty
  a_idle_wdt: assert property (p_idle_wdt) else $error("idle watchdog gate wrong"); // [RQ4]

  property p_idle_bod;
    @(posedge clk) disable iff (rst)
    in_idle |-> bod_en;
  endproperty
  a_idle_bod: assert property (p_idle_bod) else $error("bod off in idle"); // [RQ5]

  property p_idle_exit;
    @(posedge clk) disable iff (rst)
    (clk_en && in_idle && irq_pending)
    |=> (st_r == pmc_pkg::ST_RUN && cpu_clk_en && !pmc_r[pmc_pkg::PMC_IDL]);
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit failed"); // [RQ6]

  property p_pd_entry;
    @(posedge clk) disable iff (rst)
    (st_r == pmc_pkg::ST_RUN && wr_pmc && reg_wdata[pmc_pkg::PMC_PD] && !warm_rst)
    |=> (in_pd && !osc_en && !bod_en && flash_pd && !cpu_clk_en);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("pd entry failed"); // [RQ8] [RQ24]

  property p_pd_stay;
    @(posedge clk) disable iff (rst)
    (clk_en && in_pd && !rst_rise && !wake0 && !wake1) |=> in_pd;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("pd left without cause"); // [RQ10]

  property p_pd_clear;
    @(posedge clk) disable iff (rst)
    in_pd ##1 !in_pd |-> !pmc_r[pmc_pkg::PMC_PD];
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("pd bit not cleared"); // [RQ9]

  property p_timed_wake;
    @(posedge clk) disable iff (rst)
    (clk_en && in_pd && !rst_rise && (wake0 || wake1) && pmc_r[pmc_pkg::PMC_WTS])
    |=> (st_r == pmc_pkg::ST_WAKE_TIMED && osc_en && !cpu_clk_en);
  endproperty
  a_timed_wake: assert property (p_timed_wake) else $error("timed wake wrong"); // [RQ12]

  property p_ext_hold;
    @(posedge clk) disable iff (rst)
    (clk_en && st_r == pmc_pkg::ST_WAKE_EXT && !src_rise)
    |=> (st_r == pmc_pkg::ST_WAKE_EXT && !cpu_clk_en);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external wake early"); // [RQ14]

  property p_rst_pulse;
    @(posedge clk) disable iff (rst)
    (clk_en && st_r == pmc_pkg::ST_RST_WAKE && cnt_done && !rst_act) ##1 clk_en [*2]
    |-> (cpu_reset && $past(cpu_reset)) ##1 !cpu_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse not two cycles"); // [RQ17]

  property p_cold_keep;
    @(posedge clk) disable iff (rst)
    (clk_en && warm_rst) |=> (pmc_r[pmc_pkg::PMC_COLD] == $past(pmc_r[pmc_pkg::PMC_COLD]));
  endproperty
  a_cold_keep: assert property (p_cold_keep) else $error("cold flag hit by warm reset"); // [RQ18]

  property p_fe_set;
    @(posedge clk) disable iff (rst)
    (clk_en && frame_error) |=> frame_error_flag;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("frame error flag not set"); // [RQ20]

endmodule : pmc_power_mode_controller

//--- sim/pmc_board_model.sv
// board side: irq pins with pull-ups, reset pin with pull-down
`timescale 1ns/1ps
module pmc_board_model (
  // clock reference
  clk,
  // pins
  irq_zero_n,
  irq_one_n,
  reset_pin
);
  input  wire logic clk;
  output logic      irq_zero_n;
  output logic      irq_one_n;
  output logic      reset_pin;
  initial begin
    irq_zero_n = 1'b1;
    irq_one_n  = 1'b1;
    reset_pin  = 1'b0;
  end
  // low for n cycles, then the pull-up restores the pin
  task automatic irq_low(input int which, input int n);
    @(posedge clk);
    if (which == 0) irq_zero_n <= 1'b0;
    else irq_one_n <= 1'b0;
    repeat (n) @(posedge clk);
    irq_zero_n <= 1'b1;
    irq_one_n  <= 1'b1;
  endtask : irq_low
  task automatic rst_high(input int n);
    @(posedge clk);
    reset_pin <= 1'b1;
    repeat (n) @(posedge clk);
    reset_pin <= 1'b0;
  endtask : rst_high
endmodule : pmc_board_model

//--- sim/tb_top.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, reg_wr, reg_rd, warm_rst, irq_pending, i0_n, i1_n, rpin, ce, fe_ev;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        cpu_clk_en, periph_clk_en, wdt_clk_en, osc_en, bod_en, flash_pd;
  logic        port_hold, cpu_reset, ale_en, baud_double, smb, fef;
  logic [31:0] seed;
  int          errors, num_checks, m_pmc, n;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one cycle per microsecond keeps the start-up delays short
  pmc_power_mode_controller #(.CYC_PER_US(1)) pmc_power_mode_controller_inst (
    .clk(clk), .rst(rst), .clk_en(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .warm_rst(warm_rst),
    .irq_pending(irq_pending), .frame_error(fe_ev), .ext_irq_zero_n(i0_n),
    .ext_irq_one_n(i1_n), .reset_pin(rpin), .reset_polarity_pin(1'b1),
    .sut_fuse(2'h0), .clk_src_crystal(1'b0), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .osc_en(osc_en),
    .bod_en(bod_en), .flash_pd(flash_pd), .port_hold(port_hold), .cpu_reset(cpu_reset),
    .ale_en(ale_en), .baud_double(baud_double), .serial_mode_bit(smb),
    .frame_error_flag(fef));
  pmc_board_model pmc_board_model_inst (.clk(clk), .irq_zero_n(i0_n), .irq_one_n(i1_n),
    .reset_pin(rpin));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    if (a == pmc_pkg::PMC_ADDR) m_pmc = v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic wait_cpu(input int max);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < max) begin
      cyc(1);
      n++;
    end
  endtask : wait_cpu
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    errors++;
    complete_run();
  end

  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    warm_rst = 1'b0; irq_pending = 1'b0; seed = 32'h6198; m_pmc = 8'h10;
    errors = 0; num_checks = 0; ce = 1'b1; fe_ev = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(pmc_pkg::PMC_ADDR); chk("pmc", 8'h10, d);
    rd(8'h55); chk("unmapped", 8'h00, d);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(pmc_pkg::PMC_ADDR, seed[7:0] & 8'hFC);
      rd(pmc_pkg::PMC_ADDR); chk("pmc", m_pmc[7:0], d);
    end
    wr(pmc_pkg::PMC_ADDR, 8'h9C); cyc(1); chk("baud", 1, baud_double);
    @(posedge clk);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    m_pmc &= 8'h10;
    rd(pmc_pkg::PMC_ADDR); chk("pmc", m_pmc[7:0], d);
    // frame error sets the flag whichever view serial_control shows
    wr(pmc_pkg::PMC_ADDR, 8'h40);
    @(posedge clk);
    fe_ev <= 1'b1;
    @(posedge clk);
    fe_ev <= 1'b0;
    rd(pmc_pkg::SER_ADDR); chk("ser", 8'h80, d);
    wr(pmc_pkg::SER_ADDR, 8'h00); wr(pmc_pkg::PMC_ADDR, 8'h00);
    wr(pmc_pkg::SER_ADDR, 8'h80); cyc(1); chk("fef", 0, fef); chk("smb", 1, smb);
    @(posedge clk);
    fe_ev <= 1'b1;
    @(posedge clk);
    fe_ev <= 1'b0;
    cyc(1); chk("fef", 1, fef);
    wr(pmc_pkg::AUX_ADDR, 8'h03); cyc(1); chk("ale", 0, ale_en);
    rd(pmc_pkg::AUX_ADDR); chk("aux", 8'h03, d);
    // clock enable low freezes the block, so this write is lost
    @(posedge clk);
    ce <= 1'b0;
    wr(pmc_pkg::AUX_ADDR, 8'h00);
    ce <= 1'b1;
    rd(pmc_pkg::AUX_ADDR); chk("freeze", 8'h03, d);
    // idle, left by a pending interrupt
    wr(pmc_pkg::PMC_ADDR, 8'h01); cyc(2);
    chk("cpu", 0, cpu_clk_en); chk("hold", 1, port_hold);
    chk("periph", 1, periph_clk_en); chk("wdt", 0, wdt_clk_en);
    chk("bod", 1, bod_en);
    @(posedge clk);
    irq_pending <= 1'b1;
    @(posedge clk);
    irq_pending <= 1'b0;
    cyc(1); chk("cpu", 1, cpu_clk_en);
    m_pmc &= 8'hFE;
    rd(pmc_pkg::PMC_ADDR); chk("pmc", m_pmc[7:0], d);
    // timed wake, both request bits at once, pin rises early
    wr(pmc_pkg::TYPE_ADDR, 8'h00); wr(pmc_pkg::IEN_ADDR, 8'h01);
    wr(pmc_pkg::PMC_ADDR, 8'h23); cyc(2);
    chk("osc", 0, osc_en); chk("bod", 0, bod_en); chk("fpd", 1, flash_pd);
    pmc_board_model_inst.irq_low(0, 2); wait_cpu(60);
    chk("delay", 1, n >= 14 && n <= 22);
    rd(pmc_pkg::PMC_ADDR); chk("pd", 0, d[1]);
    // external wake; edge-typed source refused
    wr(pmc_pkg::TYPE_ADDR, 8'h01); wr(pmc_pkg::IEN_ADDR, 8'h05);
    wr(pmc_pkg::PMC_ADDR, 8'h02);
    pmc_board_model_inst.irq_low(0, 4); cyc(10); chk("cpu", 0, cpu_clk_en);
    fork
      pmc_board_model_inst.irq_low(1, 30);
      begin
        cyc(26);
        chk("cpu", 0, cpu_clk_en); chk("osc", 1, osc_en);
      end
    join
    wait_cpu(8); chk("cpu", 1, cpu_clk_en);
    // reset pin wake, released before the delay ends
    wr(pmc_pkg::PMC_ADDR, 8'h02); cyc(2);
    pmc_board_model_inst.rst_high(3); cyc(2); chk("cpu", 0, cpu_clk_en);
    n = 0;
    while (cpu_reset !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (cpu_reset === 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("rstlen", 8'h02, n[7:0]);
    rd(pmc_pkg::PMC_ADDR); chk("pd", 0, d[1]);
    // reset pin held past the delay keeps the core in reset until release
    wr(pmc_pkg::PMC_ADDR, 8'h02); cyc(2);
    pmc_board_model_inst.rst_high(30); chk("rsthold", 1, cpu_reset);
    cyc(4); chk("rsthold", 0, cpu_reset); chk("cpu", 1, cpu_clk_en);
    complete_run();
  end
endmodule : tb_top
